// [logic/pec_pkg.sv]
// Contract
// - Control register B only selects counters three, four
// - B bits 0-4 select counter three event
// - B bits 5-9 select counter four event
// - User mirror reads control B, read-only
// - Four 32-bit counters, overflow may raise interrupt
// - Counter bit 0 is the overflow flag
// - Counter bits 1-31 hold event count
// - Overflow once most significant bit is one
// - Interrupt needs global enable and matching control
// - Masked interrupt stays pending until external enable
// - Stop-on-interrupt freezes counters after interrupt
// - Count from selection write until clear/interrupt
// - Counter one codes 0,1,2,4 hold/cycles/completed/dispatched
// - Counter one code 3 counts time-base bit rises
// - Counter one codes 5,6,7 barrier/search/L2 hit
// - Counter one codes 8,9,10 fetch/breakpoint/slow misses
// - Counter one codes 11,12 unresolved branches/dispatch stalls; others reserved
// - Control A bits 26-31 select counter two
// - Counter two codes 0,1,2,4,5 defined
// - Counter two code 3 counts time-base bit rises
// - Taking the interrupt clears global enable
// - Control A bits 7-8 bit select, 9 rise interrupt
package pec_pkg;

    typedef logic [9:0]  pec_spr_t;
    typedef logic [31:0] pec_word_t;
    typedef logic [1:0]  pec_inc_t;

    localparam int NUM_COUNTERS = 4;

    // Special-register numbers
    localparam pec_spr_t SPR_MODE_CTRL_A      = 10'h3b8;
    localparam pec_spr_t SPR_USER_MIRROR_B    = 10'h3ac;
    localparam pec_spr_t SPR_EVENT_CTRL_B     = 10'h3bc;
    localparam pec_spr_t SPR_COUNTER [NUM_COUNTERS] = '{10'h3c0, 10'h3c1, 10'h3c2, 10'h3c3};

    // Bit 0 is the least significant bit of a word
    localparam int A_GLOBAL_OVERFLOW_IRQ_ENABLE_BIT     = 26;
    localparam int A_STOP_BIT      = 25;
    localparam int A_TBSEL_HI      = 24;
    localparam int A_TBSEL_LO      = 23;
    localparam int A_TBIRQ_BIT     = 22;
    localparam int A_C1IRQ_BIT     = 15;
    localparam int A_C234IRQ_BIT   = 14;
    localparam int A_C1SEL_HI      = 12;
    localparam int A_C1SEL_LO      = 6;
    localparam int A_C2SEL_HI      = 5;
    localparam int A_C2SEL_LO      = 0;
    localparam int B_C3SEL_HI      = 31;
    localparam int B_C3SEL_LO      = 27;
    localparam int B_C4SEL_HI      = 26;
    localparam int B_C4SEL_LO      = 22;
    localparam int CNT_OV_BIT      = 31;

    localparam pec_word_t CTRL_B_WRITE_MASK = 32'hffc0_0000;
    localparam pec_word_t CTRL_RESET        = 32'h0000_0000;
    localparam pec_word_t COUNTER_RESET     = 32'h0000_0000;
    localparam pec_word_t READ_UNMAPPED     = 32'h0000_0000;

    // Time-base bit index per select value
    localparam int TB_IDX_SEL0 = 0;
    localparam int TB_IDX_SEL1 = 8;
    localparam int TB_IDX_SEL2 = 12;
    localparam int TB_IDX_SEL3 = 16;

    localparam pec_inc_t INC_NONE = 2'h0;
    localparam pec_inc_t INC_ONE  = 2'h1;

    // Counter one codes
    localparam logic [6:0] C1_HOLD          = 7'h00;
    localparam logic [6:0] C1_CYCLES        = 7'h01;
    localparam logic [6:0] C1_COMPLETED     = 7'h02;
    localparam logic [6:0] C1_TB_RISE       = 7'h03;
    localparam logic [6:0] C1_DISPATCHED    = 7'h04;
    localparam logic [6:0] C1_BARRIER       = 7'h05;
    localparam logic [6:0] C1_ITLB_SEARCH   = 7'h06;
    localparam logic [6:0] C1_L2_HIT        = 7'h07;
    localparam logic [6:0] C1_INST_EA       = 7'h08;
    localparam logic [6:0] C1_BKPT_MATCH    = 7'h09;
    localparam logic [6:0] C1_SLOW_MISS     = 7'h0a;
    localparam logic [6:0] C1_BR_UNRESOLVED = 7'h0b;
    localparam logic [6:0] C1_DISP_STALL    = 7'h0c;

    // Counter two codes
    localparam logic [5:0] C2_HOLD          = 6'h00;
    localparam logic [5:0] C2_CYCLES        = 6'h01;
    localparam logic [5:0] C2_COMPLETED     = 6'h02;
    localparam logic [5:0] C2_TB_RISE       = 6'h03;
    localparam logic [5:0] C2_DISPATCHED    = 6'h04;
    localparam logic [5:0] C2_ICACHE_MISS   = 6'h05;

    // Counter three and four common codes
    localparam logic [4:0] C34_HOLD         = 5'h00;
    localparam logic [4:0] C34_CYCLES       = 5'h01;
    localparam logic [4:0] C34_COMPLETED    = 5'h02;
    localparam logic [4:0] C34_TB_RISE      = 5'h03;
    localparam logic [4:0] C34_DISPATCHED   = 5'h04;

    typedef struct packed {
        logic      wrEn;
        logic      rdEn;
        pec_spr_t  num;
        pec_word_t data;
    } pec_spr_req_s;

    typedef struct packed {
        logic [63:0] timeBase;
        pec_inc_t    dispatched;
        logic        cycle;
        logic        completed;
        logic        barrierDone;
        logic        itlbSearch;
        logic        l2Hit;
        logic        instEaValid;
        logic        bkptMatch;
        logic        slowLoadMiss;
        logic        branchUnresolved;
        logic        dispatchStall;
        logic        icacheMiss;
        logic [31:0] eventsThree;
        logic [31:0] eventsFour;
    } pec_events_s;

    typedef struct packed {
        pec_word_t ctrlA;
        pec_word_t ctrlB;
        logic      tbPrev;
        logic      tbPrevTwo;
        logic      pending;
        logic      halted;
        pec_word_t rdData;
        logic      rdValid;
    } pec_state_s;

    typedef struct packed {
        pec_word_t count;
    } pec_slot_s;

endpackage : pec_pkg

// [logic/pec_counter_slot.sv]
`timescale 1ns/100ps
`default_nettype none
module pec_counter_slot (
    input  wire logic               clock,
    input  wire logic               sys_rst,
    input  wire logic               loadEn,
    input  wire pec_pkg::pec_word_t loadValue,
    input  wire pec_pkg::pec_inc_t  incAmount,
    output var  pec_pkg::pec_word_t count
);

    pec_pkg::pec_slot_s state_reg;
    pec_pkg::pec_slot_s state_next;

    always_comb begin
        state_next = state_reg;
        if (loadEn) begin
            state_next.count = loadValue;
        end else begin
            // Carry into the top bit raises the overflow flag
            state_next.count = state_reg.count + 32'(incAmount);
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg.count <= pec_pkg::COUNTER_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign count = state_reg.count;

endmodule : pec_counter_slot
`default_nettype wire

// [logic/pec_counters.sv]
`timescale 1ns/100ps
`default_nettype none
module pec_counters (
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    input  wire pec_pkg::pec_spr_req_s sprReq,
    output var  pec_pkg::pec_word_t    sprRdData,
    output logic                       sprRdValid,
    input  wire pec_pkg::pec_events_s  events,
    input  wire logic                  externalIrqEnable,
    output logic                       pmIrqSignal,
    output logic                       pmExceptionTake
);

    pec_pkg::pec_state_s state_reg;
    pec_pkg::pec_state_s state_next;

    pec_pkg::pec_word_t  cnt       [pec_pkg::NUM_COUNTERS];
    pec_pkg::pec_inc_t   incAmt    [pec_pkg::NUM_COUNTERS];
    logic                loadCnt   [pec_pkg::NUM_COUNTERS];
    logic [pec_pkg::NUM_COUNTERS-1:0] overflow;

    logic       globalEnable;
    logic       stopOnInterrupt;
    logic [1:0] timeBaseBitSelect;
    logic       irqOnTimeBitRise;
    logic       counterOneIrqControl;
    logic       countersTwoToFourIrqControl;
    logic [6:0] counterOneSelector;
    logic [5:0] counterTwoSelector;
    logic [4:0] counterThreeSelector;
    logic [4:0] counterFourSelector;
    logic       tbBit;
    logic       tbRise;
    logic       tbBitTwo;
    logic       tbRiseTwo;
    logic       irqRaw;
    logic       take;
    logic       countEnable;
    logic       wrModeA;
    logic       wrCtrlB;

    // Field extraction
    assign globalEnable                = state_reg.ctrlA[pec_pkg::A_GLOBAL_OVERFLOW_IRQ_ENABLE_BIT];
    assign stopOnInterrupt             = state_reg.ctrlA[pec_pkg::A_STOP_BIT];
    assign timeBaseBitSelect           = state_reg.ctrlA[pec_pkg::A_TBSEL_HI:pec_pkg::A_TBSEL_LO];
    assign irqOnTimeBitRise            = state_reg.ctrlA[pec_pkg::A_TBIRQ_BIT];
    assign counterOneIrqControl        = state_reg.ctrlA[pec_pkg::A_C1IRQ_BIT];
    assign countersTwoToFourIrqControl = state_reg.ctrlA[pec_pkg::A_C234IRQ_BIT];
    assign counterOneSelector          = state_reg.ctrlA[pec_pkg::A_C1SEL_HI:pec_pkg::A_C1SEL_LO];
    assign counterTwoSelector          = state_reg.ctrlA[pec_pkg::A_C2SEL_HI:pec_pkg::A_C2SEL_LO];
    assign counterThreeSelector        = state_reg.ctrlB[pec_pkg::B_C3SEL_HI:pec_pkg::B_C3SEL_LO];
    assign counterFourSelector         = state_reg.ctrlB[pec_pkg::B_C4SEL_HI:pec_pkg::B_C4SEL_LO];

    assign wrModeA = sprReq.wrEn && (sprReq.num == pec_pkg::SPR_MODE_CTRL_A);
    assign wrCtrlB = sprReq.wrEn && (sprReq.num == pec_pkg::SPR_EVENT_CTRL_B);

    // Time-base bit choice for counters one, three, four and the interrupt
    always_comb begin
        unique case (timeBaseBitSelect)
            2'h0: tbBit = events.timeBase[pec_pkg::TB_IDX_SEL0];
            2'h1: tbBit = events.timeBase[pec_pkg::TB_IDX_SEL1];
            2'h2: tbBit = events.timeBase[pec_pkg::TB_IDX_SEL2];
            2'h3: tbBit = events.timeBase[pec_pkg::TB_IDX_SEL3];
        endcase
    end

    assign tbRise = tbBit && !state_reg.tbPrev;

    // Counter two takes the time-base select values in reverse order
    always_comb begin
        unique case (timeBaseBitSelect)
            2'h0: tbBitTwo = events.timeBase[pec_pkg::TB_IDX_SEL3];
            2'h1: tbBitTwo = events.timeBase[pec_pkg::TB_IDX_SEL2];
            2'h2: tbBitTwo = events.timeBase[pec_pkg::TB_IDX_SEL1];
            2'h3: tbBitTwo = events.timeBase[pec_pkg::TB_IDX_SEL0];
        endcase
    end

    assign tbRiseTwo = tbBitTwo && !state_reg.tbPrevTwo;

    // Overflow flags
    generate
        for (genvar i = 0; i < pec_pkg::NUM_COUNTERS; i++) begin : g_ov
            assign overflow[i] = cnt[i][pec_pkg::CNT_OV_BIT];
        end
    endgenerate

    // Interrupt signalling condition
    always_comb begin
        irqRaw = globalEnable &&
                 ((counterOneIrqControl && overflow[0]) ||
                  (countersTwoToFourIrqControl && (|overflow[pec_pkg::NUM_COUNTERS-1:1])) ||
                  (irqOnTimeBitRise && tbRise));
    end

    assign pmIrqSignal     = irqRaw;
    assign take            = state_reg.pending && externalIrqEnable;
    assign pmExceptionTake = take;

    // Counting stops on a frozen block
    // Freeze already in the cycle that signals the interrupt
    assign countEnable = !state_reg.halted && !(irqRaw && stopOnInterrupt);

    // Counter one event choice
    always_comb begin
        incAmt[0] = pec_pkg::INC_NONE;
        case (counterOneSelector)
            pec_pkg::C1_HOLD:          incAmt[0] = pec_pkg::INC_NONE;
            pec_pkg::C1_CYCLES:        incAmt[0] = pec_inc_t_of(events.cycle);
            pec_pkg::C1_COMPLETED:     incAmt[0] = pec_inc_t_of(events.completed);
            pec_pkg::C1_TB_RISE:       incAmt[0] = pec_inc_t_of(tbRise);
            pec_pkg::C1_DISPATCHED:    incAmt[0] = events.dispatched;
            pec_pkg::C1_BARRIER:       incAmt[0] = pec_inc_t_of(events.barrierDone);
            pec_pkg::C1_ITLB_SEARCH:   incAmt[0] = pec_inc_t_of(events.itlbSearch);
            pec_pkg::C1_L2_HIT:        incAmt[0] = pec_inc_t_of(events.l2Hit);
            pec_pkg::C1_INST_EA:       incAmt[0] = pec_inc_t_of(events.instEaValid);
            pec_pkg::C1_BKPT_MATCH:    incAmt[0] = pec_inc_t_of(events.bkptMatch);
            pec_pkg::C1_SLOW_MISS:     incAmt[0] = pec_inc_t_of(events.slowLoadMiss);
            pec_pkg::C1_BR_UNRESOLVED: incAmt[0] = pec_inc_t_of(events.branchUnresolved);
            pec_pkg::C1_DISP_STALL:    incAmt[0] = pec_inc_t_of(events.dispatchStall);
            default:                   incAmt[0] = pec_pkg::INC_NONE;
        endcase
        if (!countEnable) begin
            incAmt[0] = pec_pkg::INC_NONE;
        end
    end

    // Counter two event choice
    always_comb begin
        incAmt[1] = pec_pkg::INC_NONE;
        case (counterTwoSelector)
            pec_pkg::C2_HOLD:        incAmt[1] = pec_pkg::INC_NONE;
            pec_pkg::C2_CYCLES:      incAmt[1] = pec_inc_t_of(events.cycle);
            pec_pkg::C2_COMPLETED:   incAmt[1] = pec_inc_t_of(events.completed);
            pec_pkg::C2_TB_RISE:     incAmt[1] = pec_inc_t_of(tbRiseTwo);
            pec_pkg::C2_DISPATCHED:  incAmt[1] = events.dispatched;
            pec_pkg::C2_ICACHE_MISS: incAmt[1] = pec_inc_t_of(events.icacheMiss);
            default:                 incAmt[1] = pec_pkg::INC_NONE;
        endcase
        if (!countEnable) begin
            incAmt[1] = pec_pkg::INC_NONE;
        end
    end

    // Counters three and four share the common codes
    always_comb begin
        incAmt[2] = pick_c34(counterThreeSelector, events.eventsThree);
        incAmt[3] = pick_c34(counterFourSelector, events.eventsFour);
        if (!countEnable) begin
            incAmt[2] = pec_pkg::INC_NONE;
            incAmt[3] = pec_pkg::INC_NONE;
        end
    end

    function automatic pec_pkg::pec_inc_t pec_inc_t_of(input logic ev);
        pec_inc_t_of = ev ? pec_pkg::INC_ONE : pec_pkg::INC_NONE;
    endfunction : pec_inc_t_of

    function automatic pec_pkg::pec_inc_t pick_c34(input logic [4:0] sel, input logic [31:0] ext);
        pick_c34 = pec_pkg::INC_NONE;
        case (sel)
            pec_pkg::C34_HOLD:       pick_c34 = pec_pkg::INC_NONE;
            pec_pkg::C34_CYCLES:     pick_c34 = pec_inc_t_of(events.cycle);
            pec_pkg::C34_COMPLETED:  pick_c34 = pec_inc_t_of(events.completed);
            pec_pkg::C34_TB_RISE:    pick_c34 = pec_inc_t_of(tbRise);
            pec_pkg::C34_DISPATCHED: pick_c34 = events.dispatched;
            default:                 pick_c34 = pec_inc_t_of(ext[sel]);
        endcase
    endfunction : pick_c34

    // Counter storage
    generate
        for (genvar i = 0; i < pec_pkg::NUM_COUNTERS; i++) begin : g_slot
            assign loadCnt[i] = sprReq.wrEn && (sprReq.num == pec_pkg::SPR_COUNTER[i]);
            pec_counter_slot u_slot (
                .clock     (clock),
                .sys_rst   (sys_rst),
                .loadEn    (loadCnt[i]),
                .loadValue (sprReq.data),
                .incAmount (incAmt[i]),
                .count     (cnt[i])
            );
        end
    endgenerate

    // Control, pending and read path
    always_comb begin
        state_next         = state_reg;
        state_next.tbPrev  = tbBit;
        state_next.tbPrevTwo = tbBitTwo;
        state_next.rdValid = sprReq.rdEn;

        if (wrModeA) begin
            state_next.ctrlA = sprReq.data;
        end
        if (take) begin
            state_next.ctrlA[pec_pkg::A_GLOBAL_OVERFLOW_IRQ_ENABLE_BIT] = 1'b0;
        end
        if (wrCtrlB) begin
            state_next.ctrlB = sprReq.data & pec_pkg::CTRL_B_WRITE_MASK;
        end

        // Signal held until the core unmasks external interrupts
        if (take) begin
            state_next.pending = 1'b0;
        end else if (irqRaw) begin
            state_next.pending = 1'b1;
        end

        // Freeze released by a fresh mode write; a new freeze wins
        if (wrModeA) begin
            state_next.halted = 1'b0;
        end
        if (irqRaw && stopOnInterrupt) begin
            state_next.halted = 1'b1;
        end

        state_next.rdData = pec_pkg::READ_UNMAPPED;
        if (sprReq.rdEn) begin
            case (sprReq.num)
                pec_pkg::SPR_MODE_CTRL_A:   state_next.rdData = state_reg.ctrlA;
                pec_pkg::SPR_EVENT_CTRL_B:  state_next.rdData = state_reg.ctrlB;
                pec_pkg::SPR_USER_MIRROR_B: state_next.rdData = state_reg.ctrlB;
                pec_pkg::SPR_COUNTER[0]:    state_next.rdData = cnt[0];
                pec_pkg::SPR_COUNTER[1]:    state_next.rdData = cnt[1];
                pec_pkg::SPR_COUNTER[2]:    state_next.rdData = cnt[2];
                pec_pkg::SPR_COUNTER[3]:    state_next.rdData = cnt[3];
                default:                    state_next.rdData = pec_pkg::READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg.ctrlA   <= pec_pkg::CTRL_RESET;
            state_reg.ctrlB   <= pec_pkg::CTRL_RESET;
            state_reg.tbPrev  <= 1'b0;
            state_reg.tbPrevTwo <= 1'b0;
            state_reg.pending <= 1'b0;
            state_reg.halted  <= 1'b0;
            state_reg.rdData  <= pec_pkg::READ_UNMAPPED;
            state_reg.rdValid <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sprRdData  = state_reg.rdData;
    assign sprRdValid = state_reg.rdValid;

endmodule : pec_counters
`default_nettype wire

// [verif/pec_core_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pec_core_model (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic allowIrq,
    input  wire logic pmExceptionTake,
    output logic      externalIrqEnable,
    output int        takeCount
);
    logic tookLast;
    logic allowLast;
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tookLast <= 1'b0;
            allowLast <= 1'b0;
            takeCount <= 0;
        end else begin
            tookLast <= pmExceptionTake;
            allowLast <= allowIrq;
            if (pmExceptionTake) takeCount <= takeCount + 1;
        end
    end
    // Core masks itself on entering the handler
    always @(negedge clock or posedge sys_rst) begin
        if (sys_rst) externalIrqEnable <= 1'b0;
        else externalIrqEnable <= allowLast && !tookLast;
    end
endmodule : pec_core_model
`default_nettype wire

// [verif/pec_counters_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module pec_counters_chk (
    input wire logic                  clock,
    input wire logic                  sys_rst,
    input wire pec_pkg::pec_spr_req_s sprReq,
    input wire pec_pkg::pec_word_t    sprRdData,
    input wire logic                  sprRdValid,
    input wire pec_pkg::pec_events_s  events,
    input wire logic                  externalIrqEnable,
    input wire logic                  pmIrqSignal,
    input wire logic                  pmExceptionTake
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    pec_pkg::pec_word_t shadowB_reg;
    logic               rdA, rdB, rdM, mapped;
    assign rdA = sprReq.rdEn && sprReq.num == pec_pkg::SPR_MODE_CTRL_A;
    assign rdB = sprReq.rdEn && sprReq.num == pec_pkg::SPR_EVENT_CTRL_B;
    assign rdM = sprReq.rdEn && sprReq.num == pec_pkg::SPR_USER_MIRROR_B;
    assign mapped = sprReq.num == pec_pkg::SPR_MODE_CTRL_A || sprReq.num == pec_pkg::SPR_EVENT_CTRL_B
        || sprReq.num == pec_pkg::SPR_USER_MIRROR_B || sprReq.num[9:2] == 8'hf0;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) shadowB_reg <= 32'h0000_0000;
        else if (sprReq.wrEn && sprReq.num == pec_pkg::SPR_EVENT_CTRL_B)
            shadowB_reg <= sprReq.data & pec_pkg::CTRL_B_WRITE_MASK;
    end
    a_rd_valid_next: assert property (sprReq.rdEn |=> sprRdValid) else $error("read answer missing");
    a_no_spurious_valid: assert property (!sprReq.rdEn |=> !sprRdValid) else $error("spurious read answer");
    a_mirror_tracks_b: assert property (rdM |=> sprRdData == $past(shadowB_reg))
        else $error("mirror differs from control B");
    a_b_reserved_zero: assert property (rdB |=> sprRdData == $past(shadowB_reg))
        else $error("control B readback wrong");
    a_unmapped_reads_zero: assert property (sprReq.rdEn && !mapped |=> sprRdData == pec_pkg::READ_UNMAPPED)
        else $error("unmapped read not zero");
    a_take_needs_ee: assert property (pmExceptionTake |-> externalIrqEnable)
        else $error("exception taken while masked");
    a_pending_taken: assert property ((pmIrqSignal && !pmExceptionTake ##1 externalIrqEnable) |-> pmExceptionTake)
        else $error("pending interrupt not taken");
    a_take_drops_irq: assert property (pmExceptionTake |=> !pmIrqSignal && !pmExceptionTake)
        else $error("signal persists after take");
    a_global_overflow_irq_enable_cleared: assert property (pmExceptionTake ##1 rdA |=> !sprRdData[pec_pkg::A_GLOBAL_OVERFLOW_IRQ_ENABLE_BIT])
        else $error("global enable not cleared");
    c_take: cover property (pmExceptionTake);
    c_mirror_read: cover property (rdM);
    c_masked_irq: cover property (pmIrqSignal && !externalIrqEnable);
endmodule : pec_counters_chk
bind pec_counters pec_counters_chk u_chk (.clock(clock), .sys_rst(sys_rst), .sprReq(sprReq), .sprRdData(sprRdData),
    .sprRdValid(sprRdValid), .events(events), .externalIrqEnable(externalIrqEnable), .pmIrqSignal(pmIrqSignal),
    .pmExceptionTake(pmExceptionTake));
`default_nettype wire

// [verif/tb_perf_event_counters.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_perf_event_counters;
    logic                  clock = 1'b0;
    logic                  sys_rst = 1'b1;
    logic                  allowIrq = 1'b0;
    pec_pkg::pec_spr_req_s sprReq = '0;
    pec_pkg::pec_events_s  events = '0;
    pec_pkg::pec_word_t    sprRdData;
    logic                  sprRdValid, externalIrqEnable, pmIrqSignal, pmExceptionTake;
    int                    takeCount, n_errors = 0, num_checks = 0;
    logic [31:0]           seed = 32'h0001_18b3, got, base;
    int                    tbl1 [4] = '{0, 8, 12, 16};
    int                    tbl2 [4] = '{16, 12, 8, 0};
    always #2 clock = ~clock;
    pec_counters dut (.clock(clock), .sys_rst(sys_rst), .sprReq(sprReq), .sprRdData(sprRdData),
        .sprRdValid(sprRdValid), .events(events), .externalIrqEnable(externalIrqEnable),
        .pmIrqSignal(pmIrqSignal), .pmExceptionTake(pmExceptionTake));
    pec_core_model core (.clock(clock), .sys_rst(sys_rst), .allowIrq(allowIrq),
        .pmExceptionTake(pmExceptionTake), .externalIrqEnable(externalIrqEnable), .takeCount(takeCount));
    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : next_rand
    function automatic logic [31:0] exp_inc(int c, int code, int n);
        if (code == 0 || (c == 0 && code > 12)) return 32'h0;
        return code == 4 ? 32'(2 * n) : 32'(n);
    endfunction : exp_inc
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    task automatic spr_write(input pec_pkg::pec_spr_t num, input pec_pkg::pec_word_t data);
        @(negedge clock);
        sprReq = '{wrEn: 1'b1, rdEn: 1'b0, num: num, data: data};
        @(negedge clock);
        sprReq.wrEn = 1'b0;
    endtask : spr_write
    task automatic spr_read(input pec_pkg::pec_spr_t num, output pec_pkg::pec_word_t data);
        @(negedge clock);
        sprReq = '{wrEn: 1'b0, rdEn: 1'b1, num: num, data: 32'h0};
        @(negedge clock);
        data = sprRdValid === 1'b1 ? sprRdData : 32'hxxxx_xxxx;
        sprReq.rdEn = 1'b0;
    endtask : spr_read
    task automatic drive_events(input int c, input int code, input logic [1:0] tbs, input logic on);
        pec_pkg::pec_events_s e;
        e = '0;
        case (code)
            1: e.cycle = on;
            2: e.completed = on;
            3: e.timeBase[c == 1 ? tbl2[tbs] : tbl1[tbs]] = on;
            4: e.dispatched = on ? 2'h2 : 2'h0;
            default: begin
                if (c == 0) {e.dispatchStall, e.branchUnresolved, e.slowLoadMiss, e.bkptMatch, e.instEaValid,
                    e.l2Hit, e.itlbSearch, e.barrierDone} = 8'(on) << (code - 5);
                else if (c == 1) e.icacheMiss = on;
                else if (c == 2) e.eventsThree[code] = on;
                else e.eventsFour[code] = on;
            end
        endcase
        events = e;
    endtask : drive_events
    task automatic wait_for(input int which);
        for (int i = 0; i < 20; i++) begin
            if ((which == 0 ? pmIrqSignal : takeCount != 0) === 1'b1) return;
            @(negedge clock);
        end
        check("wait bound", 32'h1, 32'h0);
        final_report();
    endtask : wait_for
    initial begin
        int n;
        logic [1:0] tbs;
        repeat (3) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        foreach (pec_pkg::SPR_COUNTER[c]) begin
            spr_read(pec_pkg::SPR_COUNTER[c], got);
            check("counter reset", pec_pkg::COUNTER_RESET, got);
        end
        base = next_rand();
        spr_write(pec_pkg::SPR_EVENT_CTRL_B, base);
        spr_write(pec_pkg::SPR_USER_MIRROR_B, ~base);
        spr_read(pec_pkg::SPR_USER_MIRROR_B, got);
        check("mirror", base & 32'hffc0_0000, got);
        spr_read(pec_pkg::SPR_MODE_CTRL_A, got);
        check("mode A untouched", 32'h0, got);
        spr_read(10'h123, got);
        check("unmapped", 32'h0, got);
        for (int c = 0; c < 4; c++) begin
            for (int code = 0; code <= (c == 0 ? 13 : 5); code++) begin
                n = 1 + next_rand() % 8;
                tbs = 2'(next_rand());
                base = next_rand() & 32'h3fff_ffff;
                spr_write(pec_pkg::SPR_COUNTER[c], base);
                spr_write(pec_pkg::SPR_MODE_CTRL_A, 32'(tbs) << 23 | (c == 0 ? code << 6 : c == 1 ? code : 0));
                spr_write(pec_pkg::SPR_EVENT_CTRL_B, c == 2 ? code << 27 : c == 3 ? code << 22 : 0);
                for (int i = 0; i < 2 * n; i++) begin
                    drive_events(c, code, tbs, i % 2 == 0);
                    @(negedge clock);
                end
                spr_read(pec_pkg::SPR_COUNTER[c], got);
                check("count", base + exp_inc(c, code, n), got);
                check("count", base + exp_inc(c, code, n), got);
            end
        end
        spr_write(pec_pkg::SPR_COUNTER[0], 32'h7fff_fffe);
        spr_write(pec_pkg::SPR_MODE_CTRL_A, 32'h0600_8000 | 32'(pec_pkg::C1_CYCLES) << 6);
        events.cycle = 1'b1;
        wait_for(0);
        check("take while masked", 32'h0, 32'(pmExceptionTake));
        repeat (4) @(negedge clock);
        spr_read(pec_pkg::SPR_COUNTER[0], got);
        check("frozen at overflow", 32'h8000_0000, got);
        allowIrq = 1'b1;
        wait_for(1);
        @(negedge clock);
        allowIrq = 1'b0;
        check("takes", 32'h1, 32'(takeCount));
        spr_read(pec_pkg::SPR_MODE_CTRL_A, got);
        check("global enable", 32'h0, 32'(got[pec_pkg::A_GLOBAL_OVERFLOW_IRQ_ENABLE_BIT]));
        spr_write(pec_pkg::SPR_COUNTER[0], pec_pkg::COUNTER_RESET);
        spr_write(pec_pkg::SPR_COUNTER[2], 32'h7fff_fff0);
        spr_write(pec_pkg::SPR_EVENT_CTRL_B, 32'(pec_pkg::C34_CYCLES) << 27);
        spr_write(pec_pkg::SPR_MODE_CTRL_A, 32'h0400_8000);
        repeat (20) @(negedge clock);
        check("irq wrong control", 32'h0, 32'(pmIrqSignal));
        spr_write(pec_pkg::SPR_MODE_CTRL_A, 32'h0400_4000);
        check("irq counters two-four", 32'h1, 32'(pmIrqSignal));
        final_report();
    end
endmodule : tb_perf_event_counters
`default_nettype wire
